// ---- common/stfm_pkg.sv ----
// Shared constants for the S/T frame and multiframe sync block.
// Assumes a 10 MHz system clock and a decoded line bit stream on that clock.
package stfm_pkg;
  // Clock and line timing
  localparam int CLK_NS = 100; // System clock period
  localparam int BIT_NS = 5208; // One line bit at 192 kbit/s
  localparam int BIT_CYC = BIT_NS / CLK_NS; // Pulse width, rounded down
  localparam int SP_GAP_NS = 250000; // Spacing of single pulses
  localparam int SP_GAP_CYC = SP_GAP_NS / CLK_NS; // Single pulse period in cycles
  localparam int TP_W = 12; // Test pulse counter width
  // Frame layout, receive direction
  localparam logic [5:0] FRM_LAST = 6'h2f; // Bit 47 ends the frame
  localparam logic [5:0] FA_POS = 6'h0d; // Auxiliary framing bit
  localparam logic [5:0] M_POS = 6'h19; // Multiframe bit
  localparam logic [5:0] S_POS = 6'h24; // S bit
  // Alignment thresholds
  localparam logic [2:0] GOOD_NEED = 3'h4; // Good frames counted before regain
  localparam logic [1:0] BAD_LOSS = 2'h2; // Bad frames for loss
  // Multiframe
  localparam logic [4:0] MF_LEN = 5'h14; // Frames per multiframe
  localparam logic [4:0] MF_F1 = 5'h01;
  localparam logic [4:0] MF_F6 = 5'h06;
  localparam logic [4:0] MF_F11 = 5'h0b;
  localparam logic [4:0] MF_F16 = 5'h10;
  // Register map, word index on the plain port
  localparam logic [2:0] A_MODE = 3'h0; // Mode bits
  localparam logic [2:0] A_QTX = 3'h1; // q_bit_transmit_reg
  localparam logic [2:0] A_SSTAT = 3'h2; // s_bit_status_reg
  localparam logic [2:0] A_CMD = 3'h3; // Layer-1 command
  localparam logic [2:0] A_IND = 3'h4; // indication_rx_reg
  // Mode register fields
  localparam int B_MFD = 0; // multiframe_disable
  localparam int B_DLP = 1; // digital_loop_en
  localparam int B_RLP = 2; // remote_loop_en
  // Status register fields
  localparam int B_LOCK = 4; // multiframe_locked
  localparam int B_ALIGN = 5; // Frame aligned
  // Layer-1 command codes
  localparam logic [3:0] C_ECK = 4'h0; // clock_enable_cmd
  localparam logic [3:0] C_RST = 4'h1;
  localparam logic [3:0] C_SSP = 4'h2; // single_pulse_cmd
  localparam logic [3:0] C_SCP = 4'h4; // continuous_pulse_cmd
  localparam logic [3:0] C_EAL = 4'ha; // analog_loop_cmd
  localparam logic [3:0] C_DRC = 4'hf;
  // Indication codes
  localparam logic [3:0] I_CE = 4'h7;
  localparam logic [3:0] I_TI = 4'ha; // test_indication
  localparam logic [3:0] I_ATI = 4'hb; // awake_test_indication
  localparam logic [3:0] I_CD = 4'hf;
  // Reset values
  localparam logic [3:0] CMD_RST_VAL = 4'hf; // Powered down until clock enable
  localparam logic [3:0] IND_RST_VAL = 4'hf;
  // Alignment and multiframe states
  typedef enum logic [0:0] {FA_HUNT, FA_SYNC} stfm_fa_e;
  typedef enum logic [1:0] {MF_HUNT, MF_CHECK, MF_LOCK} stfm_mf_e;
endpackage

// ---- rtl/stfm_core.sv ----
// S/T terminal-side frame alignment, multiframe sync, S/Q bits and test loops.
// Assumes the line receiver delivers decoded bits with a code-violation flag
// on mclk; the line level detector arrives asynchronously from a pin.
`timescale 1ns/1ns
module stfm_core
(
  input wire logic mclk, // System clock, 10 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [2:0] reg_addr, // Register index
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic rx_bit_stb, // One received line bit
  input wire logic rx_bit, // Received bit value
  input wire logic rx_cv, // Code violation on this bit
  input wire logic line_level, // Awake detector pin, async
  output logic tx_fa_bit, // Bit for next transmitted FA slot
  output logic s_change_evt, // Pulse on change of S1..S4
  output logic frame_aligned, // Receive frame alignment held
  output logic l1_powered, // Layer 1 clocks running
  output logic hdlc_loop_sel, // HDLC tx looped to rx
  output logic pcm_loop_sel, // PCM in looped to out
  output logic loop_int_timing, // Internal timing for loops
  output logic b_remote_loop, // Received 2B back to transmitter
  output logic analog_loop_on, // Transmitter wired to receiver
  output logic line_tx_quiet, // Send nothing on the line
  output logic tx_pulse_pos, // Test pulse, positive mark
  output logic tx_pulse_neg // Test pulse, negative mark
);
  // Software state
  logic [2:0] mode_r; // Mode bits
  logic [3:0] q_bit_transmit_reg; // Q1..Q4
  logic [3:0] cmd_r; // Current layer-1 command
  logic [3:0] indication_rx_reg; // Current indication
  logic pwr_r; // Layer 1 powered
  logic multiframe_disable;
  logic digital_loop_en;
  logic remote_loop_en;
  // Receive framing
  stfm_pkg::stfm_fa_e fa_st_r; // Alignment state
  logic [5:0] idx_r; // Bit index in frame
  logic cv_ok_r; // Violation seen at bit 0
  logic cv_bad_r; // Violation seen elsewhere
  logic [2:0] good_cnt_r; // Good frames while hunting
  logic [1:0] bad_cnt_r; // Consecutive bad frames
  logic fa_rx_r; // Received FA bit
  logic m_rx_r; // Received M bit
  logic s_rx_r; // Received S bit
  logic frm_end; // Last bit of a frame
  logic frm_good; // Frame carried the bit 0 framing violation and no other
  // Multiframe
  stfm_pkg::stfm_mf_e mf_st_r; // Multiframe state
  logic [4:0] mf_num_r; // Number of the frame now arriving
  logic [4:0] mf_ok_r; // Correct frames seen in check
  logic [3:0] s_shadow_r; // S bits gathered this multiframe
  logic [3:0] s_bits_r; // Published S1..S4
  logic s_evt_r; // Change pulse
  logic tx_fa_r; // FA value for transmitter
  logic mf_match; // Frame matches expected FA/M
  logic q_frame; // Frame 1, 6, 11 or 16
  logic [1:0] q_slot; // Which of the four Q/S bits
  logic multiframe_locked;
  // Level detector sync and test pulses
  logic lvl_s1_r;
  logic lvl_s2_r;
  logic lvl_s3_r;
  logic lvl_r; // Filtered line level
  logic [stfm_pkg::TP_W-1:0] tp_cnt_r; // Test pulse timer
  logic tp_pol_r; // Current pulse polarity
  logic tp_pos_r;
  logic tp_neg_r;
  logic [7:0] rdata_r;
  logic scp_on;
  logic ssp_on;
  logic eal_on;
  logic [stfm_pkg::TP_W-1:0] tp_last;

  assign multiframe_disable = mode_r[stfm_pkg::B_MFD];
  assign digital_loop_en = mode_r[stfm_pkg::B_DLP];
  assign remote_loop_en = mode_r[stfm_pkg::B_RLP];
  assign scp_on = pwr_r && (cmd_r == stfm_pkg::C_SCP);
  assign ssp_on = pwr_r && (cmd_r == stfm_pkg::C_SSP);
  assign eal_on = pwr_r && (cmd_r == stfm_pkg::C_EAL);

  // Register writes; reset leaves layer 1 powered down
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      mode_r <= 3'h0;
      q_bit_transmit_reg <= 4'h0;
      cmd_r <= stfm_pkg::CMD_RST_VAL;
    end
    else if (reg_wr)
    begin
      if (reg_addr == stfm_pkg::A_MODE)
      begin
        mode_r <= reg_wdata[2:0];
      end
      else if (reg_addr == stfm_pkg::A_QTX)
      begin
        q_bit_transmit_reg <= reg_wdata[3:0];
      end
      else if (reg_addr == stfm_pkg::A_CMD)
      begin
        cmd_r <= reg_wdata[3:0];
      end
    end
  end

  // Power state: clock enable wakes, deactivate or layer-1 reset sleeps
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      pwr_r <= 1'b0;
    else if (cmd_r == stfm_pkg::C_ECK)
      pwr_r <= 1'b1;
    else if (cmd_r == stfm_pkg::C_DRC || cmd_r == stfm_pkg::C_RST)
      pwr_r <= 1'b0;
  end

  // Read mux; unmapped indices read zero
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == stfm_pkg::A_MODE)
        rdata_r <= {5'h00, mode_r};
      else if (reg_addr == stfm_pkg::A_QTX)
        rdata_r <= {4'h0, q_bit_transmit_reg};
      else if (reg_addr == stfm_pkg::A_SSTAT)
        rdata_r <= {2'h0, frame_aligned, multiframe_locked, s_bits_r};
      else if (reg_addr == stfm_pkg::A_CMD)
        rdata_r <= {4'h0, cmd_r};
      else if (reg_addr == stfm_pkg::A_IND)
        rdata_r <= {4'h0, indication_rx_reg};
      else
        rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // Line level pin: three stages, change accepted when last two agree
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      lvl_s1_r <= 1'b0;
      lvl_s2_r <= 1'b0;
      lvl_s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end
    else
    begin
      lvl_s1_r <= line_level;
      lvl_s2_r <= lvl_s1_r;
      lvl_s3_r <= lvl_s2_r;
      if (lvl_s2_r == lvl_s3_r)
        lvl_r <= lvl_s3_r;
    end
  end

  // Frame ends on bit 47; good only with the framing violation at bit 0 alone
  assign frm_end = pwr_r && rx_bit_stb && (idx_r == stfm_pkg::FRM_LAST);
  assign frm_good = cv_ok_r && !cv_bad_r && !rx_cv;

  // Bit counter; while hunting a violation re-anchors bit 0
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !pwr_r)
    begin
      idx_r <= 6'h00;
      cv_ok_r <= 1'b0;
      cv_bad_r <= 1'b0;
    end
    else if (rx_bit_stb)
    begin
      if (fa_st_r == stfm_pkg::FA_HUNT && rx_cv)
      begin
        idx_r <= 6'h01;
        cv_ok_r <= 1'b1;
        cv_bad_r <= 1'b0;
      end
      else
      begin
        idx_r <= (idx_r == stfm_pkg::FRM_LAST) ? 6'h00 : idx_r + 6'h01;
        if (idx_r == stfm_pkg::FRM_LAST)
        begin
          cv_ok_r <= 1'b0;
          cv_bad_r <= 1'b0;
        end
        else if (rx_cv && idx_r == 6'h00)
          cv_ok_r <= 1'b1;
        else if (rx_cv)
          cv_bad_r <= 1'b1;
      end
    end
  end

  // Capture FA, M and S bits at their slots
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      fa_rx_r <= 1'b0;
      m_rx_r <= 1'b0;
      s_rx_r <= 1'b0;
    end
    else if (rx_bit_stb)
    begin
      if (idx_r == stfm_pkg::FA_POS)
        fa_rx_r <= rx_bit;
      if (idx_r == stfm_pkg::M_POS)
        m_rx_r <= rx_bit;
      if (idx_r == stfm_pkg::S_POS)
        s_rx_r <= rx_bit;
    end
  end

  // Alignment: lose on second bad frame, regain on fifth good frame.
  // A single bad frame only bumps the counter, so noise bursts are ridden out.
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !pwr_r)
    begin
      fa_st_r <= stfm_pkg::FA_HUNT;
      good_cnt_r <= 3'h0;
      bad_cnt_r <= 2'h0;
    end
    else if (fa_st_r == stfm_pkg::FA_HUNT && rx_bit_stb && rx_cv && idx_r != 6'h00)
      good_cnt_r <= 3'h0; // Realigned: count starts over
    else if (frm_end)
    begin
      case (fa_st_r)
        stfm_pkg::FA_HUNT:
        begin
          if (!frm_good)
            good_cnt_r <= 3'h0;
          else if (good_cnt_r == stfm_pkg::GOOD_NEED)
          begin
            fa_st_r <= stfm_pkg::FA_SYNC;
            good_cnt_r <= 3'h0;
            bad_cnt_r <= 2'h0;
          end
          else
            good_cnt_r <= good_cnt_r + 3'h1;
        end
        default:
        begin
          if (frm_good)
            bad_cnt_r <= 2'h0;
          else if (bad_cnt_r + 2'h1 == stfm_pkg::BAD_LOSS)
          begin
            fa_st_r <= stfm_pkg::FA_HUNT;
            bad_cnt_r <= 2'h0;
          end
          else
            bad_cnt_r <= bad_cnt_r + 2'h1;
        end
      endcase
    end
  end
  assign frame_aligned = (fa_st_r == stfm_pkg::FA_SYNC);

  // Expected FA/M pattern of the frame now ending
  always_comb
  begin
    q_frame = 1'b0;
    q_slot = 2'h0;
    case (mf_num_r)
      stfm_pkg::MF_F1:
      begin
        q_frame = 1'b1;
        q_slot = 2'h0;
      end
      stfm_pkg::MF_F6:
      begin
        q_frame = 1'b1;
        q_slot = 2'h1;
      end
      stfm_pkg::MF_F11:
      begin
        q_frame = 1'b1;
        q_slot = 2'h2;
      end
      stfm_pkg::MF_F16:
      begin
        q_frame = 1'b1;
        q_slot = 2'h3;
      end
      default:
      begin
        q_frame = 1'b0;
        q_slot = 2'h0;
      end
    endcase
  end
  assign mf_match = (fa_rx_r == q_frame) && (m_rx_r == (mf_num_r == stfm_pkg::MF_F1));

  // Multiframe sync: start on frame 1, lock after 20 correct frames
  always_ff @(posedge mclk)
  begin
    if (!reset_n || multiframe_disable || !frame_aligned)
    begin
      mf_st_r <= stfm_pkg::MF_HUNT;
      mf_num_r <= stfm_pkg::MF_F1;
      mf_ok_r <= 5'h00;
    end
    else if (frm_end)
    begin
      mf_num_r <= (mf_num_r == stfm_pkg::MF_LEN) ? stfm_pkg::MF_F1 : mf_num_r + 5'h01;
      case (mf_st_r)
        stfm_pkg::MF_HUNT:
        begin
          mf_num_r <= stfm_pkg::MF_F1 + 5'h01;
          mf_ok_r <= 5'h01;
          if (fa_rx_r && m_rx_r)
            mf_st_r <= stfm_pkg::MF_CHECK;
          else
            mf_num_r <= stfm_pkg::MF_F1;
        end
        stfm_pkg::MF_CHECK:
        begin
          if (!mf_match)
          begin
            mf_st_r <= stfm_pkg::MF_HUNT;
            mf_num_r <= stfm_pkg::MF_F1;
          end
          else if (mf_ok_r + 5'h01 == stfm_pkg::MF_LEN)
            mf_st_r <= stfm_pkg::MF_LOCK;
          else
            mf_ok_r <= mf_ok_r + 5'h01;
        end
        default:
        begin
          if (!mf_match)
          begin
            mf_st_r <= stfm_pkg::MF_HUNT;
            mf_num_r <= stfm_pkg::MF_F1;
          end
        end
      endcase
    end
  end
  assign multiframe_locked = (mf_st_r == stfm_pkg::MF_LOCK);

  // S bits gathered per multiframe, published after frame 16
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      s_shadow_r <= 4'h0;
      s_bits_r <= 4'h0;
      s_evt_r <= 1'b0;
    end
    else
    begin
      s_evt_r <= 1'b0;
      if (frm_end && multiframe_locked && q_frame)
      begin
        s_shadow_r[q_slot] <= s_rx_r;
        if (mf_num_r == stfm_pkg::MF_F16)
        begin
          s_bits_r <= {s_rx_r, s_shadow_r[2:0]};
          s_evt_r <= ({s_rx_r, s_shadow_r[2:0]} != s_bits_r);
        end
      end
    end
  end
  assign s_change_evt = s_evt_r;

  // FA to transmit: Q bits when locked, else a mirror of the received FA
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      tx_fa_r <= 1'b0;
    else if (frm_end)
    begin
      if (multiframe_locked && mf_match)
        tx_fa_r <= q_frame && q_bit_transmit_reg[q_slot];
      else
        tx_fa_r <= fa_rx_r;
    end
  end
  assign tx_fa_bit = tx_fa_r;

  // Indication: analog loop reports TI once synced, AWAKE_TEST_INDICATION on line level
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      indication_rx_reg <= stfm_pkg::IND_RST_VAL;
    else if (!pwr_r)
      indication_rx_reg <= stfm_pkg::I_CD;
    else if (eal_on && lvl_r)
      indication_rx_reg <= stfm_pkg::I_ATI;
    else if (eal_on && frame_aligned)
      indication_rx_reg <= stfm_pkg::I_TI;
    else if ((scp_on || ssp_on) && lvl_r)
      indication_rx_reg <= stfm_pkg::I_ATI;
    else if (scp_on || ssp_on)
      indication_rx_reg <= stfm_pkg::I_TI;
    else if (cmd_r == stfm_pkg::C_ECK)
      indication_rx_reg <= stfm_pkg::I_CE;
  end

  // Loops; remote loop keeps the D channel on HDLC and bars digital loop
  assign hdlc_loop_sel = digital_loop_en && !remote_loop_en;
  assign pcm_loop_sel = digital_loop_en && !remote_loop_en;
  assign loop_int_timing = digital_loop_en && !remote_loop_en;
  assign b_remote_loop = remote_loop_en;
  assign analog_loop_on = eal_on;
  assign line_tx_quiet = eal_on || !pwr_r;

  // Test pulse timer: period is one bit for continuous, 250 us for single
  assign tp_last = scp_on ? stfm_pkg::TP_W'(stfm_pkg::BIT_CYC - 1)
                          : stfm_pkg::TP_W'(stfm_pkg::SP_GAP_CYC - 1);
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !(scp_on || ssp_on))
    begin
      tp_cnt_r <= '0;
      tp_pol_r <= 1'b0;
    end
    else if (tp_cnt_r >= tp_last)
    begin
      tp_cnt_r <= '0;
      tp_pol_r <= !tp_pol_r;
    end
    else
      tp_cnt_r <= tp_cnt_r + 1'b1;
  end

  // Pulse marks; single pulses last one bit time per period
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tp_pos_r <= 1'b0;
      tp_neg_r <= 1'b0;
    end
    else
    begin
      tp_pos_r <= (scp_on || (ssp_on && tp_cnt_r < stfm_pkg::TP_W'(stfm_pkg::BIT_CYC)))
                  && !tp_pol_r;
      tp_neg_r <= (scp_on || (ssp_on && tp_cnt_r < stfm_pkg::TP_W'(stfm_pkg::BIT_CYC)))
                  && tp_pol_r;
    end
  end
  assign tx_pulse_pos = tp_pos_r;
  assign tx_pulse_neg = tp_neg_r;
  assign l1_powered = pwr_r;

  // Checks
  a_loss_two_bad: assert property (@(posedge mclk) disable iff (!reset_n)
    frame_aligned && frm_end && !frm_good && bad_cnt_r == 2'h1 |=> !frame_aligned)
    else $error("alignment not lost after two bad frames");
  a_one_bad_kept: assert property (@(posedge mclk) disable iff (!reset_n)
    frame_aligned && frm_end && !frm_good && bad_cnt_r == 2'h0 && pwr_r |=> frame_aligned)
    else $error("alignment lost on one bad frame");
  a_regain_fifth: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(frame_aligned) |-> $past(good_cnt_r) == stfm_pkg::GOOD_NEED)
    else $error("alignment regained on wrong frame");
  a_lock_count: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(multiframe_locked) |-> $past(mf_ok_r) == 5'h13)
    else $error("multiframe lock without 20 frames");
  a_mfd_clears: assert property (@(posedge mclk) disable iff (!reset_n)
    multiframe_disable |=> !multiframe_locked)
    else $error("lock bit set while disabled");
  a_mirror_fa: assert property (@(posedge mclk) disable iff (!reset_n)
    frm_end && !multiframe_locked |=> tx_fa_bit == $past(fa_rx_r))
    else $error("FA not mirrored while unlocked");
  a_s_event: assert property (@(posedge mclk) disable iff (!reset_n)
    s_change_evt |-> s_bits_r != $past(s_bits_r))
    else $error("S event without change");
  a_quiet_eal: assert property (@(posedge mclk) disable iff (!reset_n)
    analog_loop_on |-> line_tx_quiet ##1 (!tx_pulse_pos && !tx_pulse_neg))
    else $error("line driven during analog loop");
  a_reset_pdown: assert property (@(posedge mclk)
    !reset_n |=> !l1_powered)
    else $error("powered after reset");
  a_scp_alt: assert property (@(posedge mclk) disable iff (!reset_n)
    scp_on && $stable(cmd_r) && tp_pos_r ##1 scp_on && !tp_pos_r |-> tp_neg_r)
    else $error("continuous pulses not alternating");
endmodule

// ---- tb/stfm_nt_model.sv ----
// Network termination model: 48-bit line frames, one bit every 4 clocks.
// Assumes the block samples rx_bit and rx_cv only with rx_bit_stb.
`timescale 1ns/1ns
module stfm_nt_model
(
  input wire logic mclk, // System clock
  input wire logic run, // Frames flow while high
  input wire logic bad, // Drop the framing mark
  input wire logic [3:0] s_tx, // S1..S4 to send
  output logic rx_bit_stb, // Bit strobe
  output logic rx_bit, // Bit value
  output logic rx_cv // Framing violation
);
  logic [1:0] div_r; // Clocks within a bit
  logic [5:0] idx_r; // Bit within a frame
  logic [4:0] fn_r; // Frame number less one
  logic fa; // Auxiliary framing bit of this frame
  // Counters stop and clear between runs
  always_ff @(posedge mclk)
  begin
    div_r <= run ? div_r + 2'h1 : 2'h0;
    if (!run)
    begin
      idx_r <= 6'h00;
      fn_r <= 5'h00;
    end
    else if (div_r == 2'h3)
    begin
      idx_r <= (idx_r == 6'h2f) ? 6'h00 : idx_r + 6'h01;
      if (idx_r == 6'h2f)
        fn_r <= (fn_r == 5'h13) ? 5'h00 : fn_r + 5'h01;
    end
  end
  assign fa = (fn_r % 5) == 0;
  assign rx_bit_stb = run && div_r == 2'h3;
  // Off the strobe the line toggles, so a stale bit is never trusted
  assign rx_bit = !rx_bit_stb ? div_r[0] : idx_r == 6'h0d ? fa :
    idx_r == 6'h19 ? fn_r == 5'h00 : idx_r == 6'h24 ? fa && s_tx[fn_r / 5] : 1'b1;
  assign rx_cv = rx_bit_stb && idx_r == 6'h00 && !bad;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the S/T frame and multiframe sync block.
// Assumes the package and stfm_nt_model are compiled first.
`timescale 1ns/1ns
module tb_top;
  localparam int FRM = 192; // Clocks per line frame
  logic mclk, reset_n, reg_wr, reg_rd, line_level, run, bad; // Stimulus
  logic [2:0] reg_addr; // Register index
  logic [7:0] reg_wdata, reg_rdata, d; // Port data, last read
  logic [3:0] s_tx; // S bits sent
  logic rx_bit_stb, rx_bit, rx_cv, tx_fa_bit, s_change_evt, frame_aligned;
  logic l1_powered, hdlc_loop_sel, pcm_loop_sel, loop_int_timing, b_remote_loop;
  logic analog_loop_on, line_tx_quiet, tx_pulse_pos, tx_pulse_neg;
  logic [15:0] n; // Measured count
  int mismatches; // Mismatches seen
  int checked; // Comparisons made
  stfm_core DUT (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_bit_stb, .rx_bit, .rx_cv, .line_level, .tx_fa_bit, .s_change_evt, .frame_aligned,
    .l1_powered, .hdlc_loop_sel, .pcm_loop_sel, .loop_int_timing, .b_remote_loop,
    .analog_loop_on, .line_tx_quiet, .tx_pulse_pos, .tx_pulse_neg);
  stfm_nt_model NT (.mclk, .run, .bad, .s_tx, .rx_bit_stb, .rx_bit, .rx_cv);
  // 10 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands from the cycle after the strobe until the next read
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Whole frames, ending just after an edge
  task automatic fr(input int k);
    repeat (k * FRM) @(posedge mclk);
    #1;
  endtask
  // Park just after the framing bit strobe
  task automatic to_frame;
    do
      fr(0);
    while (NT.idx_r !== 6'h01 || NT.div_r !== 2'h0);
  endtask
  // Clocks until a pulse mark reaches a level, bounded
  task automatic till(input bit neg, input logic lvl);
    n = 16'h0000;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end
    while ((neg ? tx_pulse_neg : tx_pulse_pos) !== lvl && n < 16'h1388);
  endtask
  // Twenty frames of transmitted FA ones
  task automatic cnt;
    n = 16'h0000;
    repeat (20)
    begin
      fr(1);
      n += {15'h0000, tx_fa_bit};
    end
  endtask
  // Reset state, then power up by clock enable
  task automatic t_reset;
    rd(stfm_pkg::A_IND);
    chk("indication", d, {4'h0, stfm_pkg::IND_RST_VAL});
    rd(3'h7);
    chk("unmapped", d, 8'h00);
    chk("powered down", {l1_powered, line_tx_quiet}, 2'b01);
    wr(stfm_pkg::A_CMD, {4'h0, stfm_pkg::C_ECK});
    fr(1);
    chk("powered up", {l1_powered, line_tx_quiet}, 2'b10);
    rd(stfm_pkg::A_IND);
    chk("clock enabled", d, {4'h0, stfm_pkg::I_CE});
  endtask
  // One bad frame kept, two lose, fifth good frame regains
  task automatic t_align;
    run <= 1'b1;
    fr(8);
    chk("aligned", frame_aligned, 1'b1);
    to_frame;
    bad <= 1'b1;
    fr(1);
    bad <= 1'b0;
    fr(2);
    chk("one bad", frame_aligned, 1'b1);
    bad <= 1'b1;
    fr(2);
    bad <= 1'b0;
    chk("first bad", frame_aligned, 1'b1);
    fr(1);
    chk("two bad", frame_aligned, 1'b0);
    fr(4);
    chk("four good", frame_aligned, 1'b0);
    fr(1);
    chk("fifth good", frame_aligned, 1'b1);
  endtask
  // Lock, S capture and change event, Q insertion, disable and mirroring
  task automatic t_multi;
    wr(stfm_pkg::A_QTX, 8'h0a);
    fr(60);
    rd(stfm_pkg::A_SSTAT);
    chk("lock status", d, {4'h3, s_tx});
    s_tx <= 4'ha;
    n = 16'h0000;
    while (s_change_evt !== 1'b1 && n < 16'h2000)
    begin
      @(posedge mclk);
      #1 n++;
    end
    chk("s event", s_change_evt, 1'b1);
    rd(stfm_pkg::A_SSTAT);
    chk("new s bits", d, 8'h3a);
    cnt;
    chk("q ones", n, 16'h0002);
    wr(stfm_pkg::A_MODE, 8'h01);
    fr(2);
    rd(stfm_pkg::A_SSTAT);
    chk("disabled lock", d[5:4], 2'b10);
    cnt;
    chk("mirror ones", n, 16'h0004);
  endtask
  // Continuous and single pulses, analog loop indications
  task automatic t_pulse;
    wr(stfm_pkg::A_CMD, {4'h0, stfm_pkg::C_SCP});
    till(0, 1'b1);
    till(0, 1'b0);
    chk("scp width", n, 16'(stfm_pkg::BIT_CYC));
    chk("scp alternate", tx_pulse_neg, 1'b1);
    wr(stfm_pkg::A_CMD, {4'h0, stfm_pkg::C_SSP});
    till(0, 1'b0);
    till(0, 1'b1);
    till(1, 1'b1);
    chk("ssp spacing", n, 16'(stfm_pkg::SP_GAP_CYC));
    wr(stfm_pkg::A_CMD, {4'h0, stfm_pkg::C_EAL});
    fr(8);
    chk("analog", {analog_loop_on, line_tx_quiet}, 2'b11);
    rd(stfm_pkg::A_IND);
    chk("ti", d, {4'h0, stfm_pkg::I_TI});
    @(posedge mclk);
    line_level <= 1'b1;
    fr(1);
    rd(stfm_pkg::A_IND);
    chk("ati", d, {4'h0, stfm_pkg::I_ATI});
  endtask
  // Digital loop alone, then blocked by remote loop
  task automatic t_loops;
    wr(stfm_pkg::A_MODE, 8'h02);
    fr(0);
    chk("digital", {hdlc_loop_sel, pcm_loop_sel, loop_int_timing, b_remote_loop}, 4'he);
    wr(stfm_pkg::A_MODE, 8'h06);
    fr(0);
    chk("remote", {hdlc_loop_sel, pcm_loop_sel, loop_int_timing, b_remote_loop}, 4'h1);
  endtask
  // Verdict and end of run
  task automatic final_report;
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    mismatches = 0;
    checked = 0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    line_level = 1'b0;
    run = 1'b0;
    bad = 1'b0;
    s_tx = 4'h5;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_align;
    t_multi;
    t_pulse;
    t_loops;
    final_report;
  end
  // Watchdog, well past the expected run
  initial
  begin
    #(80000 * 100);
    mismatches++;
    final_report;
  end
endmodule
